/* include/acc_cmp_pkg.sv */
package acc_cmp_pkg;
	localparam int ACC_W = 32;
	localparam logic [3:0] LAST_IDX = 4'h8;
	localparam logic [7:0] INS_READIO = 8'h0F;
	localparam logic [7:0] INS_ARITH = 8'h13;
	localparam logic [7:0] INS_CMP = 8'h14;
	localparam logic [7:0] INS_JUMP = 8'h15;
	typedef enum logic [3:0] {
		OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_LOAD
	} arith_op_e;
	localparam logic [7:0] OP_TYPE_MAX = 8'h09;
	localparam logic [7:0] null_result_cond = 8'h00;
	localparam logic [7:0] nonnull_result_cond = 8'h01;
	localparam logic [7:0] same_value_cond = 8'h02;
	localparam logic [7:0] differ_cond = 8'h03;
	localparam logic [7:0] greater_cond = 8'h04;
	localparam logic [7:0] greater_or_same_cond = 8'h05;
	localparam logic [7:0] below_cond = 8'h06;
	localparam logic [7:0] below_or_same_cond = 8'h07;
	localparam logic [7:0] timeout_error_cond = 8'h08;
	localparam logic [7:0] alarm_input_cond = 8'h09;
	localparam logic [7:0] deviation_error_cond = 8'h0A;
	localparam logic [7:0] position_error_cond = 8'h0B;
	localparam int ERR_TIMEOUT = 0;
	localparam int ERR_ALARM = 1;
	localparam int ERR_DEVIATION = 2;
	localparam int ERR_POSITION = 3;
	localparam logic [7:0] STATUS_OK = 8'h64;
	localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
	localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
	localparam logic [7:0] BANK_IN = 8'h00;
	localparam logic [7:0] BANK_OUT = 8'h02;
	localparam logic [7:0] N_OUT = 8'h04;
	localparam logic [7:0] PORT_ENABLE = 8'h0A;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ACC = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam int CTRL_MY_LSB = 0;
	localparam int CTRL_HOST_LSB = 8;
	localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
	localparam logic [7:0] DEF_HOST_ADDR = 8'h02;
	localparam int STAT_ZERO = 0;
	localparam int STAT_BELOW = 1;
	localparam int STAT_ERR_LSB = 4;
	localparam int STAT_PC_LSB = 16;
	localparam int PC_W_MAX = 16;
endpackage

/* include/alu_if.sv */
`timescale 1ns/1ps
interface alu_if;
	acc_cmp_pkg::arith_op_e op;
	logic [acc_cmp_pkg::ACC_W-1:0] acc;
	logic [acc_cmp_pkg::ACC_W-1:0] operand;
	logic [acc_cmp_pkg::ACC_W-1:0] result;
	logic div_zero;
	modport core (output op, output acc, output operand, input result, input div_zero);
	modport alu (input op, input acc, input operand, output result, output div_zero);
endinterface

/* sim/frame_host.sv */
`timescale 1ns/1ps
module frame_host (
	input wire logic clk,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic tx_ready
);
	int hangs = 0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// the sink stalls now and then so the reply shifter has to hold its byte
	always @(posedge clk) begin
		tx_ready <= ($urandom_range(3) != 0);
	end
	// entered just after a rising edge; returns once the reply has drained
	task automatic send(input logic [7:0] adr, ins, typ, bank, input logic [31:0] val, input bit bad);
		logic [7:0] b [9];
		logic [7:0] sum;
		int n;
		b = '{adr, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
		sum = 8'h00;
		for (int i = 0; i < 8; i++) begin
			sum += b[i];
		end
		b[8] = bad ? sum + 8'h01 : sum;
		for (int i = 0; i < 10; i++) begin
			if (i < 9) begin
				rx_valid <= 1'b1;
				rx_data <= b[i];
			end else begin
				rx_valid <= 1'b0;
				rx_data <= ~b[8];
			end
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!rx_ready && n < 300);
			if (n >= 300) begin
				hangs++;
			end
		end
	endtask
endmodule // frame_host

/* sim/test_accumulator_compare_branch.sv */
`timescale 1ns/1ps
module test_accumulator_compare_branch;
	import acc_cmp_pkg::*;
	typedef struct {
		logic [7:0] tgt;
		logic [7:0] status;
		logic [7:0] instr;
		logic [31:0] value;
		bit chk;
	} reply_s;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic [7:0] RX_DATA, TX_DATA, PRG_INSTR, PRG_TYPE;
	logic RX_VALID, RX_READY, TX_VALID, TX_READY, PRG_VALID, PRG_READY, ENABLE_IN, REG_WR, REG_RD;
	logic [31:0] PRG_VALUE, REG_WDATA, REG_RDATA;
	logic [15:0] PRG_PC;
	logic [3:0] OUT_STATE, ERR_FLAGS, REG_ADDR;
	int failures = 0;
	int tests_run = 0;
	reply_s rep_q[$];
	logic [31:0] rd_q[$];
	logic [15:0] pc_q[$];
	logic [7:0] my_addr = DEF_MODULE_ADDR;
	logic [7:0] rb [9];
	int nb = 0;
	bit rd_p = 0;
	bit pc_p = 0;
	bit stuck = 0;

	accumulator_compare_branch #(.PC_W(16)) uut (.CLK_SYS(CLK_SYS), .RST(RST), .RX_DATA(RX_DATA),
		.RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.PRG_VALID(PRG_VALID), .PRG_READY(PRG_READY), .PRG_INSTR(PRG_INSTR), .PRG_TYPE(PRG_TYPE),
		.PRG_VALUE(PRG_VALUE), .PRG_PC(PRG_PC), .OUT_STATE(OUT_STATE), .ENABLE_IN(ENABLE_IN),
		.ERR_FLAGS(ERR_FLAGS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA));
	frame_host host (.clk(CLK_SYS), .rx_ready(RX_READY), .rx_data(RX_DATA), .rx_valid(RX_VALID),
		.tx_ready(TX_READY));

	initial begin
		forever #10 CLK_SYS = ~CLK_SYS;
	end

	task automatic check(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		failures += host.hangs + rep_q.size() + rd_q.size() + pc_q.size();
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// oldest expectation is taken off whenever a reply, read word or pc update shows up
	always @(posedge CLK_SYS) begin
		logic [7:0] s;
		reply_s e;
		if (rd_p) begin
			check(REG_RDATA, rd_q.pop_front());
		end
		if (pc_p) begin
			check({16'h0000, PRG_PC}, {16'h0000, pc_q.pop_front()});
		end
		rd_p = REG_RD;
		pc_p = PRG_VALID && PRG_READY;
		if (TX_VALID && TX_READY) begin
			rb[nb] = TX_DATA;
			nb++;
		end
		if (nb == 9) begin
			nb = 0;
			e = rep_q.pop_front();
			check({24'h0, rb[0]}, {24'h0, DEF_HOST_ADDR});
			check({24'h0, rb[1]}, {24'h0, e.tgt});
			check({24'h0, rb[2]}, {24'h0, e.status});
			check({24'h0, rb[3]}, {24'h0, e.instr});
			if (e.chk) begin
				check({rb[4], rb[5], rb[6], rb[7]}, e.value);
			end
			s = 8'h00;
			for (int i = 0; i < 8; i++) begin
				s += rb[i];
			end
			check({24'h0, rb[8]}, {24'h0, s});
		end
		// a hung handshake ends the run at once rather than at the global limit
		if (stuck || host.hangs > 0) begin
			finish_test();
		end
	end

	task automatic frame(input logic [7:0] ins, typ, bank, st, input logic [31:0] val, rv, input bit chk);
		rep_q.push_back('{my_addr, st, ins, rv, chk});
		host.send(my_addr, ins, typ, bank, val, 1'b0);
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge CLK_SYS);
		rd_q.push_back(exp);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask

	task automatic step(input logic [7:0] ins, typ, input logic [31:0] val, input logic [15:0] p);
		int n;
		@(posedge CLK_SYS);
		pc_q.push_back(p);
		PRG_VALID <= 1'b1;
		PRG_INSTR <= ins;
		PRG_TYPE <= typ;
		PRG_VALUE <= val;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (!PRG_READY && n < 50);
		if (n >= 50) begin
			failures++;
			stuck = 1'b1;
		end
		PRG_VALID <= 1'b0;
	endtask

	function automatic logic [31:0] arith(input int op, input logic [31:0] a, b);
		case (op)
			0: return a + b;
			1: return a - b;
			2: return a * b;
			3: return $signed(a) / $signed(b);
			4: return $signed(a) % $signed(b);
			5: return a & b;
			6: return a | b;
			7: return a ^ b;
			8: return ~a;
			default: return b;
		endcase
	endfunction

	initial begin
		logic [31:0] a, b, t;
		logic [3:0] o;
		logic [15:0] pc;
		bit same, below, tk;
		int c;
		{PRG_VALID, REG_WR, REG_RD, ENABLE_IN} = 4'h0;
		{PRG_INSTR, PRG_TYPE, PRG_VALUE, REG_WDATA} = '0;
		{OUT_STATE, ERR_FLAGS, REG_ADDR} = 12'h000;
		pc = 16'h0000;
		void'($urandom(32'hC25B));
		repeat (4) @(posedge CLK_SYS);
		RST <= 1'b0;
		reg_rd(REG_CTRL, {16'h0000, DEF_HOST_ADDR, DEF_MODULE_ADDR});
		reg_rd(4'hF, 32'h0);
		reg_wr(REG_CTRL, 32'h0000_0205);
		my_addr = 8'h05;
		reg_rd(REG_CTRL, 32'h0000_0205);
		host.send(DEF_MODULE_ADDR, INS_ARITH, 8'h09, 8'h00, 32'h1234, 1'b0);
		rep_q.push_back('{my_addr, STATUS_BAD_CSUM, INS_ARITH, 32'h0, 1'b0});
		host.send(my_addr, INS_ARITH, 8'h09, 8'h00, 32'h5678, 1'b1);
		reg_rd(REG_ACC, 32'h0);
		for (int r = 0; r < 30; r++) begin
			a = $urandom;
			b = (r < 10) ? $urandom : $urandom_range(9) + 1;
			frame(INS_ARITH, 8'h09, 8'h00, STATUS_OK, a, a, 1'b1);
			frame(INS_ARITH, r % 10, 8'h00, STATUS_OK, b, b, 1'b1);
			reg_rd(REG_ACC, arith(r % 10, a, b));
		end
		frame(INS_ARITH, 8'h0A, 8'h00, STATUS_BAD_TYPE, 32'h5, 32'h0, 1'b0);
		frame(8'h30, 8'h00, 8'h00, STATUS_BAD_CMD, 32'h0, 32'h0, 1'b0);
		// division by zero keeps the accumulator, which still holds the last load
		frame(INS_ARITH, 8'h03, 8'h00, STATUS_OK, 32'h0, 32'h0, 1'b1);
		reg_rd(REG_ACC, b);
		for (int p = 0; p < 4; p++) begin
			o = $urandom;
			OUT_STATE <= o;
			frame(INS_READIO, p, BANK_OUT, STATUS_OK, 32'h0, {31'h0, o[p]}, 1'b1);
		end
		frame(INS_READIO, 8'h04, BANK_OUT, STATUS_BAD_TYPE, 32'h0, 32'h0, 1'b0);
		for (int e = 0; e < 2; e++) begin
			ENABLE_IN <= e[0];
			frame(INS_READIO, PORT_ENABLE, BANK_IN, STATUS_OK, 32'h0, {31'h0, ~e[0]}, 1'b1);
		end
		// compare and jump go only through stored program steps
		for (int i = 0; i < 36; i++) begin
			c = i % 12;
			a = $urandom_range(20);
			b = a + $urandom_range(2) - 1;
			t = $urandom;
			o = $urandom;
			ERR_FLAGS <= o;
			same = (a == b);
			below = ($signed(a) < $signed(b));
			case (c)
				0, 2: tk = same;
				1, 3: tk = !same;
				4: tk = !same && !below;
				5: tk = !below;
				6: tk = below;
				7: tk = below || same;
				default: tk = o[c - 8];
			endcase
			step(INS_ARITH, OP_LOAD, a, pc + 16'h1);
			step(INS_CMP, $urandom, b, pc + 16'h2);
			pc = pc + 16'h2;
			pc = tk ? t[15:0] : pc + 16'h1;
			step(INS_JUMP, c, t, pc);
			reg_rd(REG_STAT, {pc, 8'h00, o, 2'b00, below, same});
		end
		repeat (3) @(posedge CLK_SYS);
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge CLK_SYS);
		failures++;
		finish_test();
	end
endmodule // test_accumulator_compare_branch

/* verilog/accumulator_alu.sv */
`timescale 1ns/1ps
module accumulator_alu (
	alu_if.alu a
);
	import acc_cmp_pkg::*;
	logic signed [ACC_W-1:0] sa;
	logic signed [ACC_W-1:0] sb;
	assign sa = a.acc;
	assign sb = a.operand;
	assign a.div_zero = (a.operand == '0);
	// two's complement throughout, products keep only the low word
	always_comb begin
		a.result = a.acc;
		case (a.op)
			OP_ADD: a.result = a.acc + a.operand;
			OP_SUB: a.result = a.acc - a.operand;
			OP_MUL: a.result = sa * sb;
			OP_DIV: begin
				if (!a.div_zero) begin
					a.result = sa / sb;
				end
			end
			OP_MOD: begin
				if (!a.div_zero) begin
					a.result = sa % sb;
				end
			end
			OP_AND: a.result = a.acc & a.operand;
			OP_OR: a.result = a.acc | a.operand;
			OP_XOR: a.result = a.acc ^ a.operand;
			OP_NOT: a.result = ~a.acc;
			OP_LOAD: a.result = a.operand;
			default: a.result = a.acc;
		endcase
	end
endmodule // accumulator_alu

/* verilog/accumulator_compare_branch.sv */
`timescale 1ns/1ps
// Contract
// - read-io of bank 2, port 0..3 returns the latched output line as 0/1.
// - read-io port 10 bank 0 returns 0 when enabled, 1 when not.
// - instruction 19 applies the selected operation with the value operand to the accumulator.
// - types 0..4 add, subtract, multiply, divide, modulo the accumulator by operand.
// - types 5..7 store accumulator AND, OR, XOR operand.
// - type 8 inverts the accumulator bitwise, operand ignored.
// - type 9 loads the operand into the accumulator.
// - accumulator operation frame is answered with status 100, value don't care.
// - compare, code 20, ignores type and bank; operand from value field.
// - compare sets status flags from accumulator versus operand for later jumps.
// - conditional jump, code 21, takes its address from value, ignores bank.
// - jump loads the program counter only when the selected condition holds.
// - conditions 0..7: zero, nonzero, equal, unequal, greater, greater-equal, lower, lower-equal.
// - conditions 8..11 test timeout, alarm, deviation, position error flags.
// - reply: host, target, status, instruction, value MSB first, checksum; success 64 hex.
module accumulator_compare_branch #(
	parameter int PC_W = 16
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	input wire logic PRG_VALID,
	output logic PRG_READY,
	input wire logic [7:0] PRG_INSTR,
	input wire logic [7:0] PRG_TYPE,
	input wire logic [acc_cmp_pkg::ACC_W-1:0] PRG_VALUE,
	output logic [PC_W-1:0] PRG_PC,
	input wire logic [3:0] OUT_STATE,
	input wire logic ENABLE_IN,
	input wire logic [3:0] ERR_FLAGS,
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);
	import acc_cmp_pkg::*;

	if (PC_W < 1 || PC_W > PC_W_MAX) begin : g_bad_pc_w
		$error("PC_W must be 1..16");
	end

	typedef enum logic {ST_RX, ST_TX} link_state_e;

	link_state_e st_q;
	logic [3:0] rx_cnt_q;
	logic [7:0] rx_q [0:LAST_IDX-1];
	logic [7:0] sum_q;
	logic [7:0] tx_q [0:LAST_IDX];
	logic [3:0] tx_cnt_q;
	logic [ACC_W-1:0] acc_q;
	logic zero_q;
	logic below_q;
	logic [PC_W-1:0] pc_q;
	logic [7:0] my_addr_q;
	logic [7:0] host_addr_q;
	logic [31:0] rdata_q;
	logic rx_take;
	logic frame_done;
	logic frame_ours;
	logic csum_ok;
	logic frame_exec;
	logic prg_exec;
	logic x_go;
	logic [7:0] f_instr;
	logic [7:0] f_type;
	logic [7:0] f_bank;
	logic [ACC_W-1:0] f_value;
	logic [7:0] x_instr;
	logic [7:0] x_type;
	logic [ACC_W-1:0] x_value;
	logic acc_wr;
	logic jump_hit;
	logic io_out;
	logic io_en;
	logic io_bit;
	logic [7:0] rep_status;
	logic [ACC_W-1:0] rep_value;
	logic [7:0] rep [0:LAST_IDX-1];
	logic [7:0] rep_sum;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;

	function automatic logic cond_true(input logic [7:0] kind, input logic z, input logic b,
		input logic [3:0] err);
		case (kind)
			null_result_cond: return z;
			nonnull_result_cond: return !z;
			same_value_cond: return z;
			differ_cond: return !z;
			greater_cond: return !z && !b;
			greater_or_same_cond: return !b;
			below_cond: return b;
			below_or_same_cond: return b || z;
			timeout_error_cond: return err[ERR_TIMEOUT];
			alarm_input_cond: return err[ERR_ALARM];
			deviation_error_cond: return err[ERR_DEVIATION];
			position_error_cond: return err[ERR_POSITION];
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] frame_sum(input logic [7:0] b [0:LAST_IDX-1]);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < LAST_IDX; i++) begin
			s = s + b[i];
		end
		return s;
	endfunction

	// receive side: a frame is taken byte by byte, the ninth byte is the checksum
	assign RX_READY = (st_q == ST_RX);
	assign rx_take = RX_READY && RX_VALID;
	assign frame_done = rx_take && (rx_cnt_q == LAST_IDX);
	assign frame_ours = (rx_q[0] == my_addr_q);
	assign csum_ok = (RX_DATA == sum_q);
	assign frame_exec = frame_done && frame_ours && csum_ok;

	assign f_instr = rx_q[1];
	assign f_type = rx_q[2];
	assign f_bank = rx_q[3];
	assign f_value = {rx_q[4], rx_q[5], rx_q[6], rx_q[7]};

	// no inter-byte timeout: a lost byte shifts framing until the checksum rejects it
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rx_cnt_q <= 4'h0;
			sum_q <= 8'h00;
		end else if (rx_take) begin
			if (rx_cnt_q == LAST_IDX) begin
				rx_cnt_q <= 4'h0;
				sum_q <= 8'h00;
			end else begin
				rx_cnt_q <= rx_cnt_q + 4'h1;
				sum_q <= sum_q + RX_DATA;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rx_take && rx_cnt_q != LAST_IDX) begin
			rx_q[rx_cnt_q[2:0]] <= RX_DATA;
		end
	end

	// a host frame has priority; the program step simply waits one cycle
	assign PRG_READY = !frame_exec;
	assign prg_exec = PRG_VALID && !frame_exec;
	assign x_go = frame_exec || PRG_VALID;
	assign x_instr = frame_exec ? f_instr : PRG_INSTR;
	assign x_type = frame_exec ? f_type : PRG_TYPE;
	assign x_value = frame_exec ? f_value : PRG_VALUE;

	alu_if a_bus ();

	assign a_bus.op = arith_op_e'(x_type[3:0]);
	assign a_bus.acc = acc_q;
	assign a_bus.operand = x_value;

	accumulator_alu u_alu (
		.a(a_bus.alu)
	);

	// division by zero leaves the accumulator untouched rather than writing garbage
	assign acc_wr = x_go && (x_instr == INS_ARITH) && (x_type <= OP_TYPE_MAX)
		&& !(a_bus.div_zero && (a_bus.op == OP_DIV || a_bus.op == OP_MOD));

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			acc_q <= '0;
		end else if (acc_wr) begin
			acc_q <= a_bus.result;
		end
	end

	// compare looks only at the value field, type and bank are not decoded
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			zero_q <= 1'b0;
			below_q <= 1'b0;
		end else if (x_go && x_instr == INS_CMP) begin
			zero_q <= (acc_q == x_value);
			below_q <= ($signed(acc_q) < $signed(x_value));
		end
	end

	assign jump_hit = cond_true(x_type, zero_q, below_q, ERR_FLAGS);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			pc_q <= '0;
		end else if (x_go && x_instr == INS_JUMP && jump_hit) begin
			pc_q <= x_value[PC_W-1:0];
		end else if (prg_exec) begin
			pc_q <= pc_q + 1'b1;
		end
	end

	assign PRG_PC = pc_q;

	assign io_out = (f_bank == BANK_OUT) && (f_type < N_OUT);
	assign io_en = (f_bank == BANK_IN) && (f_type == PORT_ENABLE);
	assign io_bit = io_out ? OUT_STATE[f_type[1:0]] : !ENABLE_IN;

	always_comb begin
		rep_status = STATUS_OK;
		rep_value = '0;
		if (!csum_ok) begin
			rep_status = STATUS_BAD_CSUM;
		end else if (f_instr == INS_ARITH) begin
			if (f_type > OP_TYPE_MAX) begin
				rep_status = STATUS_BAD_TYPE;
			end else begin
				rep_value = f_value;
			end
		end else if (f_instr == INS_READIO) begin
			if (io_out || io_en) begin
				rep_value = {{(ACC_W-1){1'b0}}, io_bit};
			end else begin
				rep_status = STATUS_BAD_TYPE;
			end
		end else if (f_instr != INS_CMP && f_instr != INS_JUMP) begin
			rep_status = STATUS_BAD_CMD;
		end
	end

	assign rep[0] = host_addr_q;
	assign rep[1] = my_addr_q;
	assign rep[2] = rep_status;
	assign rep[3] = f_instr;
	assign rep[4] = rep_value[31:24];
	assign rep[5] = rep_value[23:16];
	assign rep[6] = rep_value[15:8];
	assign rep[7] = rep_value[7:0];
	assign rep_sum = frame_sum(rep);

	// transmit: the reply is a shift register, so TX_DATA always comes from a flop
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_q <= ST_RX;
			tx_cnt_q <= 4'h0;
			for (int i = 0; i <= LAST_IDX; i++) begin
				tx_q[i] <= 8'h00;
			end
		end else begin
			case (st_q)
				ST_RX: begin
					if (frame_done && frame_ours) begin
						st_q <= ST_TX;
						tx_cnt_q <= 4'h0;
						for (int i = 0; i < LAST_IDX; i++) begin
							tx_q[i] <= rep[i];
						end
						tx_q[LAST_IDX] <= rep_sum;
					end
				end
				ST_TX: begin
					if (TX_READY) begin
						for (int i = 0; i < LAST_IDX; i++) begin
							tx_q[i] <= tx_q[i+1];
						end
						tx_q[LAST_IDX] <= 8'h00;
						if (tx_cnt_q == LAST_IDX) begin
							st_q <= ST_RX;
						end else begin
							tx_cnt_q <= tx_cnt_q + 4'h1;
						end
					end
				end
				default: st_q <= ST_RX;
			endcase
		end
	end

	assign TX_VALID = (st_q == ST_TX);
	assign TX_DATA = tx_q[0];

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			my_addr_q <= DEF_MODULE_ADDR;
			host_addr_q <= DEF_HOST_ADDR;
		end else if (REG_WR && REG_ADDR == REG_CTRL) begin
			my_addr_q <= REG_WDATA[CTRL_MY_LSB +: 8];
			host_addr_q <= REG_WDATA[CTRL_HOST_LSB +: 8];
		end
	end

	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_MY_LSB +: 8] = my_addr_q;
		ctrl_word[CTRL_HOST_LSB +: 8] = host_addr_q;
		stat_word = '0;
		stat_word[STAT_ZERO] = zero_q;
		stat_word[STAT_BELOW] = below_q;
		stat_word[STAT_ERR_LSB +: 4] = ERR_FLAGS;
		stat_word[STAT_PC_LSB +: PC_W] = pc_q;
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata_q <= '0;
		end else if (REG_RD) begin
			if (REG_ADDR == REG_CTRL) begin
				rdata_q <= ctrl_word;
			end else if (REG_ADDR == REG_ACC) begin
				rdata_q <= acc_q;
			end else if (REG_ADDR == REG_STAT) begin
				rdata_q <= stat_word;
			end else begin
				rdata_q <= '0;
			end
		end else begin
			rdata_q <= '0;
		end
	end

	assign REG_RDATA = rdata_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_io_out_read;
		frame_exec && f_instr == INS_READIO && f_bank == BANK_OUT && f_type < N_OUT;
	endsequence

	sequence s_last_sent;
		st_q == ST_TX && TX_READY && tx_cnt_q == LAST_IDX;
	endsequence

	a_io_out_echo: assert property (s_io_out_read |=>
		{tx_q[4], tx_q[5], tx_q[6], tx_q[7]} == {{(ACC_W-1){1'b0}}, $past(OUT_STATE[f_type[1:0]])})
		else $error("output line readback wrong");

	a_enable_level: assert property (
		frame_exec && f_instr == INS_READIO && f_bank == BANK_IN && f_type == PORT_ENABLE
		|=> tx_q[7][0] == !$past(ENABLE_IN) && tx_q[6] == 8'h00)
		else $error("enable level readback wrong");

	a_arith_add: assert property (
		x_go && x_instr == INS_ARITH && x_type == 8'(OP_ADD)
		|=> acc_q == $past(acc_q) + $past(x_value))
		else $error("add result wrong");

	a_logic_and: assert property (
		x_go && x_instr == INS_ARITH && x_type == 8'(OP_AND)
		|=> acc_q == ($past(acc_q) & $past(x_value)))
		else $error("and result wrong");

	a_acc_invert: assert property (
		x_go && x_instr == INS_ARITH && x_type == 8'(OP_NOT) |=> acc_q == ~$past(acc_q))
		else $error("invert result wrong");

	a_acc_load: assert property (
		x_go && x_instr == INS_ARITH && x_type == 8'(OP_LOAD) |=> acc_q == $past(x_value))
		else $error("load result wrong");

	a_arith_reply_ok: assert property (
		frame_exec && f_instr == INS_ARITH && f_type <= OP_TYPE_MAX
		|=> tx_q[2] == STATUS_OK && tx_q[3] == INS_ARITH && tx_q[0] == host_addr_q ##1 TX_VALID)
		else $error("arith reply header wrong");

	a_cmp_flags: assert property (x_go && x_instr == INS_CMP |=>
		zero_q == ($past(acc_q) == $past(x_value)) && below_q == ($signed($past(acc_q)) < $signed($past(x_value))))
		else $error("compare flags wrong");

	a_jump_taken: assert property (
		x_go && x_instr == INS_JUMP && jump_hit |=> pc_q == $past(x_value[PC_W-1:0]))
		else $error("jump not taken");

	a_jump_skip: assert property (
		prg_exec && PRG_INSTR == INS_JUMP && !jump_hit |=> pc_q == $past(pc_q) + 1'b1)
		else $error("jump taken without condition");

	a_bad_checksum: assert property (
		frame_done && frame_ours && !csum_ok
		|=> tx_q[2] == STATUS_BAD_CSUM && (acc_q == $past(acc_q) || $past(PRG_VALID)))
		else $error("bad checksum not reported");

	a_reply_end: assert property (s_last_sent |=> st_q == ST_RX && RX_READY)
		else $error("reply not nine bytes");

endmodule // accumulator_compare_branch
